// File: hdl/tct_pkg.sv
/*
 Package for the three-timer counter unit: register offsets, field positions,
 reset values, mode encodings and carrier structs.
 Assumes a plain byte-wide register port with one-cycle strobes.
*/
package tct_pkg;
	// Register offsets (byte addresses on the register port)
	localparam logic [7:0] TCT_ADDR_CTRL = 8'h88;
	localparam logic [7:0] TCT_ADDR_MODE = 8'h89;
	localparam logic [7:0] TCT_ADDR_T0L = 8'h8A;
	localparam logic [7:0] TCT_ADDR_T1L = 8'h8B;
	localparam logic [7:0] TCT_ADDR_T0H = 8'h8C;
	localparam logic [7:0] TCT_ADDR_T1H = 8'h8D;
	localparam logic [7:0] TCT_ADDR_CKSEL = 8'h8E;
	localparam logic [7:0] TCT_ADDR_T2CTRL = 8'hC8;
	localparam logic [7:0] TCT_ADDR_CAPL = 8'hCA;
	localparam logic [7:0] TCT_ADDR_CAPH = 8'hCB;
	localparam logic [7:0] TCT_ADDR_T2L = 8'hCC;
	localparam logic [7:0] TCT_ADDR_T2H = 8'hCD;
	localparam logic [7:0] TCT_ADDR_IEN = 8'hA8;

	// Timer control register fields
	localparam int TCT_CTRL_T0RUN = 4;
	localparam int TCT_CTRL_T0OVF = 5;
	localparam int TCT_CTRL_T1RUN = 6;
	localparam int TCT_CTRL_T1OVF = 7;
	// Mode register fields: timer0 in [3:0], timer1 in [7:4]
	localparam int TCT_MODE_GATE = 3;
	localparam int TCT_MODE_CT = 2;
	// Clock select fields
	localparam int TCT_CK_T0 = 3;
	localparam int TCT_CK_T1 = 4;
	localparam int TCT_CK_T2 = 5;
	localparam logic [7:0] TCT_CK_MASK = 8'h38;
	// Timer 2 control fields
	localparam int TCT_T2_CPRL = 0;
	localparam int TCT_T2_CT = 1;
	localparam int TCT_T2_RUN = 2;
	localparam int TCT_T2_EXEN = 3;
	localparam int TCT_T2_BAUD_R = 4;
	localparam int TCT_T2_BAUD_T = 5;
	localparam int TCT_T2_OVF = 7;
	// Interrupt enable fields
	localparam int TCT_IEN_T0 = 0;
	localparam int TCT_IEN_T1 = 1;
	localparam int TCT_IEN_T2 = 2;

	localparam logic [7:0] TCT_RST_BYTE = 8'h00;
	localparam logic [3:0] TCT_DIV_LAST = 4'hB;

	typedef enum logic [1:0] {
		TCT_M13 = 2'h0,
		TCT_M16 = 2'h1,
		TCT_M8R = 2'h2,
		TCT_MSPL = 2'h3
	} tct_mode_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} tct_bus_t;

	typedef struct packed {
		logic ext_interrupt0_pin;
		logic ext_interrupt1_pin;
		logic timer0_count_pin;
		logic timer1_count_pin;
		logic timer2_count_pin;
		logic timer2_capture_pin;
	} tct_pins_t;
endpackage

// File: hdl/tct_top.sv
/*
 Three-timer counter unit: timers 0 and 1 with 13-bit, 16-bit and 8-bit
 auto-reload modes, timer 2 as a 16-bit timer/counter with capture.
 Assumes pins already synchronous to i_mclk and a register master that
 issues one-cycle strobes, reading data the cycle after a read strobe.
*/
// Design decision made here: the address-and-strobe port.
// Notes on behaviour
// - Outside split mode, timer 0 counts only when run set and gating off or interrupt pin high.
// - Setting run never clears or preloads the count.
// - Timer 1 mode 0 is a 13-bit counter, handled like timer 0.
// - Mode 1 uses all 16 bits of low and high bytes.
// - Mode 2 counts in the low byte; high byte holds reload.
// - Mode 2 wrap sets timer 0 overflow flag and reloads low byte.
// - Timer 0 interrupt request follows its flag when enabled.
// - Reload leaves the high byte unchanged.
// - Timer 1 mode 2 behaves like timer 0 with its own flag.
// - Clock select bit 3 picks undivided or divide-by-12 clock for timer 0.
// - Clock select bit 4 does the same for timer 1.
// - Clock select bit 5 does the same for timer 2.
// - Timer 2 clock select ignored in baud mode or counter mode.
// - Unused clock select bits read zero, writes ignored.
// - Falling capture pin edge copies timer 2 count into capture registers.
// - Timer 2 counts clock, or falling count-pin edges in counter mode.
// - Timer 2 wrap outside baud mode sets its overflow flag and requests interrupt.
// - Capture mode needs capture select and run both set.
// - Capture edges are ignored while external enable is clear.
`timescale 1ns/100ps
`default_nettype none
module tct_top (
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_nrst,
	// Register port
	input wire tct_pkg::tct_bus_t i_bus,
	output logic [7:0] o_rdata,
	// External pins
	input wire tct_pkg::tct_pins_t i_pins,
	// Interrupt requests: timer 0, timer 1, timer 2
	output logic [2:0] o_irq
);
	import tct_pkg::*;

	logic [7:0] ctrl, next_ctrl;
	logic [7:0] mode, next_mode;
	logic [7:0] cksel, next_cksel;
	logic [7:0] t2ctrl, next_t2ctrl;
	logic [7:0] ien, next_ien;
	logic [7:0] t0l, next_t0l, t0h, next_t0h;
	logic [7:0] t1l, next_t1l, t1h, next_t1h;
	logic [15:0] t2, next_t2;
	logic [15:0] cap, next_cap;
	logic [7:0] rdata, next_rdata;
	logic [3:0] div, next_div;
	tct_pins_t pins_q, next_pins_q;
	logic [2:0] irq, next_irq;

	// Clock enable for timer `sel`: undivided or one in twelve
	function automatic logic tick(input logic sel, input logic div12);
		return sel | div12;
	endfunction

	// Gated count request for timers 0/1
	function automatic logic run_ok(input logic run, input logic gate, input logic pin);
		return run & (~gate | pin);
	endfunction

	logic div12;
	logic t0_inc, t1_inc, t2_inc;
	logic t0_ovf, t1_ovf, t0h_ovf, t2_ovf, cap_ev;
	logic t2_baud;
	logic wr;

	always_comb begin
		wr = i_bus.wr;
		div12 = (div == TCT_DIV_LAST);
		next_div = div12 ? 4'h0 : div + 4'h1;
		next_pins_q = i_pins;
	end

	// Count enables, register writes and counter updates
	always_comb begin
		// Timer 0/1 increment: timer when C/T clear, else falling count-pin edge
		t0_inc = run_ok(ctrl[TCT_CTRL_T0RUN], mode[TCT_MODE_GATE], i_pins.ext_interrupt0_pin) &
			(mode[TCT_MODE_CT] ? (pins_q.timer0_count_pin & ~i_pins.timer0_count_pin) :
			tick(cksel[TCT_CK_T0], div12));
		t1_inc = run_ok(ctrl[TCT_CTRL_T1RUN], mode[4 + TCT_MODE_GATE], i_pins.ext_interrupt1_pin) &
			(mode[4 + TCT_MODE_CT] ? (pins_q.timer1_count_pin & ~i_pins.timer1_count_pin) :
			tick(cksel[TCT_CK_T1], div12));
		t2_baud = t2ctrl[TCT_T2_BAUD_R] | t2ctrl[TCT_T2_BAUD_T];
		if (t2ctrl[TCT_T2_CT]) begin
			t2_inc = pins_q.timer2_count_pin & ~i_pins.timer2_count_pin;
		end else if (t2_baud) begin
			t2_inc = 1'b1;
		end else begin
			t2_inc = tick(cksel[TCT_CK_T2], div12);
		end
		t2_inc = t2_inc & t2ctrl[TCT_T2_RUN];
		cap_ev = t2ctrl[TCT_T2_CPRL] & t2ctrl[TCT_T2_RUN] & t2ctrl[TCT_T2_EXEN] &
			pins_q.timer2_capture_pin & ~i_pins.timer2_capture_pin;

		next_ctrl = ctrl;
		next_mode = mode;
		next_cksel = cksel;
		next_t2ctrl = t2ctrl;
		next_ien = ien;
		next_t0l = t0l;
		next_t0h = t0h;
		next_t1l = t1l;
		next_t1h = t1h;
		next_t2 = t2;
		next_cap = cap;
		t0_ovf = 1'b0;
		t1_ovf = 1'b0;
		t0h_ovf = 1'b0;
		t2_ovf = 1'b0;

		// Software writes first; hardware updates below win over them
		if (wr) begin
			if (i_bus.addr == TCT_ADDR_CTRL) begin
				next_ctrl = i_bus.wdata;
			end else if (i_bus.addr == TCT_ADDR_MODE) begin
				next_mode = i_bus.wdata;
			end else if (i_bus.addr == TCT_ADDR_T0L) begin
				next_t0l = i_bus.wdata;
			end else if (i_bus.addr == TCT_ADDR_T1L) begin
				next_t1l = i_bus.wdata;
			end else if (i_bus.addr == TCT_ADDR_T0H) begin
				next_t0h = i_bus.wdata;
			end else if (i_bus.addr == TCT_ADDR_T1H) begin
				next_t1h = i_bus.wdata;
			end else if (i_bus.addr == TCT_ADDR_CKSEL) begin
				next_cksel = i_bus.wdata & TCT_CK_MASK;
			end else if (i_bus.addr == TCT_ADDR_T2CTRL) begin
				next_t2ctrl = i_bus.wdata;
			end else if (i_bus.addr == TCT_ADDR_IEN) begin
				next_ien = i_bus.wdata;
			end else if (i_bus.addr == TCT_ADDR_CAPL) begin
				next_cap[7:0] = i_bus.wdata;
			end else if (i_bus.addr == TCT_ADDR_CAPH) begin
				next_cap[15:8] = i_bus.wdata;
			end else if (i_bus.addr == TCT_ADDR_T2L) begin
				next_t2[7:0] = i_bus.wdata;
			end else if (i_bus.addr == TCT_ADDR_T2H) begin
				next_t2[15:8] = i_bus.wdata;
			end
		end

		// Timer 0
		if (t0_inc) begin
			case (tct_mode_t'(mode[1:0]))
				TCT_M13: begin
					// Five-bit prescale in low byte, eight bits in high byte
					next_t0l = {t0l[7:5], t0l[4:0] + 5'h01};
					if (t0l[4:0] == 5'h1F) begin
						next_t0h = t0h + 8'h01;
						t0_ovf = (t0h == 8'hFF);
					end
				end
				TCT_M16: begin
					{next_t0h, next_t0l} = {t0h, t0l} + 16'h0001;
					t0_ovf = ({t0h, t0l} == 16'hFFFF);
				end
				TCT_M8R: begin
					next_t0l = (t0l == 8'hFF) ? t0h : t0l + 8'h01;
					t0_ovf = (t0l == 8'hFF);
				end
				default: begin
					// Split mode: low byte counts alone
					next_t0l = t0l + 8'h01;
					t0_ovf = (t0l == 8'hFF);
				end
			endcase
		end
		// In split mode the high byte runs off timer 1's run bit and sets its flag
		if (tct_mode_t'(mode[1:0]) == TCT_MSPL && ctrl[TCT_CTRL_T1RUN] &&
			tick(cksel[TCT_CK_T0], div12)) begin
			next_t0h = t0h + 8'h01;
			t0h_ovf = (t0h == 8'hFF);
		end

		// Timer 1; mode 3 holds it stopped
		if (t1_inc) begin
			case (tct_mode_t'(mode[5:4]))
				TCT_M13: begin
					next_t1l = {t1l[7:5], t1l[4:0] + 5'h01};
					if (t1l[4:0] == 5'h1F) begin
						next_t1h = t1h + 8'h01;
						t1_ovf = (t1h == 8'hFF);
					end
				end
				TCT_M16: begin
					{next_t1h, next_t1l} = {t1h, t1l} + 16'h0001;
					t1_ovf = ({t1h, t1l} == 16'hFFFF);
				end
				TCT_M8R: begin
					next_t1l = (t1l == 8'hFF) ? t1h : t1l + 8'h01;
					t1_ovf = (t1l == 8'hFF);
				end
				default: begin
					next_t1l = t1l;
				end
			endcase
		end

		// Timer 2
		if (t2_inc) begin
			next_t2 = t2 + 16'h0001;
			t2_ovf = (t2 == 16'hFFFF) && !t2_baud;
		end
		if (cap_ev) begin
			next_cap = t2;
		end

		// Flags: a set in the same cycle as a clear wins
		if (t0_ovf) begin
			next_ctrl[TCT_CTRL_T0OVF] = 1'b1;
		end
		if (t1_ovf | t0h_ovf) begin
			next_ctrl[TCT_CTRL_T1OVF] = 1'b1;
		end
		if (t2_ovf) begin
			next_t2ctrl[TCT_T2_OVF] = 1'b1;
		end
		// Capture flag in bit 6 when capture event seen
		if (cap_ev) begin
			next_t2ctrl[6] = 1'b1;
		end

	end

	// Requests follow the flags and enables as they stand after this edge
	always_comb begin
		next_irq[0] = next_ctrl[TCT_CTRL_T0OVF] & next_ien[TCT_IEN_T0];
		next_irq[1] = next_ctrl[TCT_CTRL_T1OVF] & next_ien[TCT_IEN_T1];
		next_irq[2] = (next_t2ctrl[TCT_T2_OVF] | next_t2ctrl[6]) & next_ien[TCT_IEN_T2];

	end

	// Read data for the next cycle
	always_comb begin
		next_rdata = 8'h00;
		if (i_bus.rd) begin
			if (i_bus.addr == TCT_ADDR_CTRL) begin
				next_rdata = ctrl;
			end else if (i_bus.addr == TCT_ADDR_MODE) begin
				next_rdata = mode;
			end else if (i_bus.addr == TCT_ADDR_T0L) begin
				next_rdata = t0l;
			end else if (i_bus.addr == TCT_ADDR_T1L) begin
				next_rdata = t1l;
			end else if (i_bus.addr == TCT_ADDR_T0H) begin
				next_rdata = t0h;
			end else if (i_bus.addr == TCT_ADDR_T1H) begin
				next_rdata = t1h;
			end else if (i_bus.addr == TCT_ADDR_CKSEL) begin
				next_rdata = cksel & TCT_CK_MASK;
			end else if (i_bus.addr == TCT_ADDR_T2CTRL) begin
				next_rdata = t2ctrl;
			end else if (i_bus.addr == TCT_ADDR_IEN) begin
				next_rdata = ien;
			end else if (i_bus.addr == TCT_ADDR_CAPL) begin
				next_rdata = cap[7:0];
			end else if (i_bus.addr == TCT_ADDR_CAPH) begin
				next_rdata = cap[15:8];
			end else if (i_bus.addr == TCT_ADDR_T2L) begin
				next_rdata = t2[7:0];
			end else if (i_bus.addr == TCT_ADDR_T2H) begin
				next_rdata = t2[15:8];
			end
		end
	end

	// Prescaler and pin history; a zero history can never fake a falling edge
	always_ff @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			div <= 4'h0;
			pins_q <= '0;
		end else begin
			div <= next_div;
			pins_q <= next_pins_q;
		end
	end

	// Control registers and counters
	always_ff @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			ctrl <= TCT_RST_BYTE;
			mode <= TCT_RST_BYTE;
			cksel <= TCT_RST_BYTE;
			t2ctrl <= TCT_RST_BYTE;
			ien <= TCT_RST_BYTE;
			t0l <= TCT_RST_BYTE;
			t0h <= TCT_RST_BYTE;
			t1l <= TCT_RST_BYTE;
			t1h <= TCT_RST_BYTE;
			t2 <= 16'h0000;
			cap <= 16'h0000;
		end else begin
			ctrl <= next_ctrl;
			mode <= next_mode;
			cksel <= next_cksel;
			t2ctrl <= next_t2ctrl;
			ien <= next_ien;
			t0l <= next_t0l;
			t0h <= next_t0h;
			t1l <= next_t1l;
			t1h <= next_t1h;
			t2 <= next_t2;
			cap <= next_cap;
		end
	end

	// Interrupt request levels
	always_ff @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			irq <= 3'h0;
		end else begin
			irq <= next_irq;
		end
	end

	// Read data register; zero outside the slot after a read strobe
	always_ff @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			rdata <= TCT_RST_BYTE;
		end else begin
			rdata <= next_rdata;
		end
	end

	assign o_rdata = rdata;
	assign o_irq = irq;
endmodule
`default_nettype wire

// File: dv/tct_top_sva.sv
/* Checker bound to tct_top; shadows software writes to predict read data.
 Assumes only the register port changes control bits, counters aside. */
`timescale 1ns/100ps
`default_nettype none
module tct_top_sva (
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_nrst,
	// Register port, pins and requests
	input wire tct_pkg::tct_bus_t i_bus,
	input wire logic [7:0] o_rdata,
	input wire tct_pkg::tct_pins_t i_pins,
	input wire logic [2:0] o_irq
);
	import tct_pkg::*;
	logic [7:0] ck, ien, ctl, md, t0h, t1h, t0l, t1l;
	logic h0ok, h1ok, l0ok, l1ok;
	wire logic wmd = i_bus.wr && i_bus.addr == TCT_ADDR_MODE;
	wire logic go0 = ctl[4] && (!md[3] || i_pins.ext_interrupt0_pin);
	wire logic go1 = ctl[6] && (!md[7] || i_pins.ext_interrupt1_pin);
	// Ok flags: the written byte still stands because the timer could not move
	always_ff @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			{ck, ien, ctl, md, t0h, t1h, t0l, t1l} <= '0;
			{h0ok, h1ok, l0ok, l1ok} <= '0;
		end else begin
			if (i_bus.wr) begin
				case (i_bus.addr)
					TCT_ADDR_CKSEL: ck <= i_bus.wdata;
					TCT_ADDR_IEN: ien <= i_bus.wdata;
					TCT_ADDR_CTRL: ctl <= i_bus.wdata;
					TCT_ADDR_MODE: md <= i_bus.wdata;
					TCT_ADDR_T0H: t0h <= i_bus.wdata;
					TCT_ADDR_T1H: t1h <= i_bus.wdata;
					TCT_ADDR_T0L: t0l <= i_bus.wdata;
					TCT_ADDR_T1L: t1l <= i_bus.wdata;
					default: ;
				endcase
			end
			h0ok <= (i_bus.wr && i_bus.addr == TCT_ADDR_T0H) ? md[1:0] == 2'h2 :
				h0ok && !(wmd && i_bus.wdata[1:0] != 2'h2);
			h1ok <= (i_bus.wr && i_bus.addr == TCT_ADDR_T1H) ? md[5:4] == 2'h2 :
				h1ok && !(wmd && i_bus.wdata[5:4] != 2'h2);
			l0ok <= !go0 && (l0ok || (i_bus.wr && i_bus.addr == TCT_ADDR_T0L));
			l1ok <= !go1 && (l1ok || (i_bus.wr && i_bus.addr == TCT_ADDR_T1L));
		end
	end
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_nrst);
	rdata_idle_a: assert property (!$past(i_bus.rd) |-> o_rdata == 8'h00)
		else $error("read data outside its slot");
	unmapped_zero_a: assert property ($past(i_bus.rd) && !($past(i_bus.addr) inside
		{[8'h88:8'h8E], 8'hA8, 8'hC8, [8'hCA:8'hCD]}) |-> o_rdata == 8'h00)
		else $error("unmapped read not zero");
	cksel_read_a: assert property ($past(i_bus.rd && i_bus.addr == TCT_ADDR_CKSEL) |->
		o_rdata == ($past(ck) & TCT_CK_MASK)) else $error("clock select readback wrong");
	irq_enable_a: assert property ((o_irq & ~ien[2:0] & ~$past(ien[2:0])) == 3'h0)
		else $error("request while disabled");
	t0_reload_a: assert property ($past(i_bus.rd && i_bus.addr == TCT_ADDR_T0H && h0ok) |->
		o_rdata == $past(t0h)) else $error("timer0 reload byte changed");
	t1_reload_a: assert property ($past(i_bus.rd && i_bus.addr == TCT_ADDR_T1H && h1ok) |->
		o_rdata == $past(t1h)) else $error("timer1 reload byte changed");
	t0_hold_a: assert property ($past(i_bus.rd && i_bus.addr == TCT_ADDR_T0L && l0ok) |->
		o_rdata == $past(t0l)) else $error("timer0 moved while held");
	t1_hold_a: assert property ($past(i_bus.rd && i_bus.addr == TCT_ADDR_T1L && l1ok) |->
		o_rdata == $past(t1l)) else $error("timer1 moved while held");
endmodule
bind tct_top tct_top_sva u_sva (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_bus(i_bus),
	.o_rdata(o_rdata), .i_pins(i_pins), .o_irq(o_irq));
`default_nettype wire

// File: dv/tct_pin_model.sv
/* Far-side pin model: gate, count and capture pins of the timer unit.
 Assumes the bench asks for pins held low by mask; idle pins sit high. */
`timescale 1ns/100ps
`default_nettype none
module tct_pin_model (
	// Clock
	input wire logic i_mclk,
	// Pins to hold low, bit order as the pin struct
	input wire logic [5:0] i_low,
	// Pin levels
	output var tct_pkg::tct_pins_t o_pins
);
	import tct_pkg::*;
	initial o_pins = '1;
	// Levels move one cycle after a request, as a synchronised source would
	always @(posedge i_mclk) begin
		o_pins <= ~i_low;
	end
endmodule
`default_nettype wire

// File: dv/test_timer_counter_trio.sv
/* Self-checking bench for tct_top through its register port.
 Assumes the pin model on the pins and the checker bound to the top. */
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin err_count++; \
	$display("FAIL %s exp %0h got %0h", n, e, g); end end
module test_timer_counter_trio;
	import tct_pkg::*;
	logic i_mclk = 1'b0;
	logic i_nrst = 1'b0;
	tct_bus_t bus = '0;
	tct_pins_t pins;
	logic [7:0] rdata;
	logic [7:0] d;
	logic [2:0] irq;
	logic [5:0] low = '0;
	int err_count = 0;
	int samples_checked = 0;
	always #5 i_mclk = ~i_mclk;
	tct_pin_model PM (.i_mclk(i_mclk), .i_low(low), .o_pins(pins));
	tct_top DUT (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_bus(bus), .o_rdata(rdata),
		.i_pins(pins), .o_irq(irq));
	task automatic bw(input logic [7:0] a, input logic [7:0] v);
		@(posedge i_mclk);
		bus.wr <= 1'b1;
		bus.addr <= a;
		bus.wdata <= v;
		@(posedge i_mclk);
		bus.wr <= 1'b0;
	endtask
	task automatic br(input logic [7:0] a);
		@(posedge i_mclk);
		bus.rd <= 1'b1;
		bus.addr <= a;
		@(posedge i_mclk);
		bus.rd <= 1'b0;
		#1 d = rdata;
	endtask
	task automatic pulse(input int b);
		@(posedge i_mclk);
		low[b] <= 1'b1;
		@(posedge i_mclk);
		low[b] <= 1'b0;
		repeat (3) @(posedge i_mclk);
	endtask
	task automatic t_regs;
		br(TCT_ADDR_CKSEL);
		`CHK("cksel reset", 8'h00, d)
		bw(TCT_ADDR_CKSEL, 8'hFF);
		br(TCT_ADDR_CKSEL);
		`CHK("cksel unused", 8'h38, d)
		br(8'h90);
		`CHK("unmapped", 8'h00, d)
	endtask
	task automatic t_gate;
		bw(TCT_ADDR_MODE, 8'h08);
		bw(TCT_ADDR_T0L, 8'h05);
		low[5] <= 1'b1;
		bw(TCT_ADDR_CTRL, 8'h10);
		repeat (20) @(posedge i_mclk);
		br(TCT_ADDR_T0L);
		`CHK("gated hold", 8'h05, d)
		low[5] <= 1'b0;
		repeat (4) @(posedge i_mclk);
		bw(TCT_ADDR_CTRL, 8'h00);
		br(TCT_ADDR_T0L);
		`CHK("count kept", 1'b1, d > 8'h05 && d < 8'h20)
	endtask
	task automatic t_rate;
		bw(TCT_ADDR_MODE, 8'h01);
		bw(TCT_ADDR_T0L, 8'hFE);
		bw(TCT_ADDR_T0H, 8'h00);
		bw(TCT_ADDR_CTRL, 8'h10);
		repeat (3) @(posedge i_mclk);
		bw(TCT_ADDR_CTRL, 8'h00);
		br(TCT_ADDR_T0H);
		`CHK("carry high", 8'h01, d)
		bw(TCT_ADDR_CKSEL, 8'h00);
		bw(TCT_ADDR_T0L, 8'h00);
		bw(TCT_ADDR_CTRL, 8'h10);
		repeat (58) @(posedge i_mclk);
		bw(TCT_ADDR_CTRL, 8'h00);
		br(TCT_ADDR_T0L);
		`CHK("div rate", 1'b1, d >= 8'h04 && d <= 8'h06)
	endtask
	task automatic t_reload;
		bw(TCT_ADDR_MODE, 8'h22);
		bw(TCT_ADDR_CKSEL, 8'h18);
		bw(TCT_ADDR_T0H, 8'hF0);
		bw(TCT_ADDR_T1H, 8'hE0);
		bw(TCT_ADDR_T0L, 8'hFE);
		bw(TCT_ADDR_T1L, 8'hFE);
		bw(TCT_ADDR_IEN, 8'h03);
		bw(TCT_ADDR_CTRL, 8'h50);
		repeat (6) @(posedge i_mclk);
		br(TCT_ADDR_CTRL);
		`CHK("flags", 8'hF0, d)
		`CHK("irq pair", 3'h3, irq)
		bw(TCT_ADDR_CTRL, 8'h00);
		br(TCT_ADDR_T0L);
		`CHK("t0 reloaded", 1'b1, d >= 8'hF0)
		br(TCT_ADDR_T0H);
		`CHK("t0 reload", 8'hF0, d)
		br(TCT_ADDR_T1L);
		`CHK("t1 reloaded", 1'b1, d >= 8'hE0)
		`CHK("irq clear", 3'h0, irq)
	endtask
	task automatic t_13bit;
		bw(TCT_ADDR_MODE, 8'h00);
		bw(TCT_ADDR_T1L, 8'h1F);
		bw(TCT_ADDR_T1H, 8'h12);
		br(TCT_ADDR_T1L);
		`CHK("t1 stopped", 8'h1F, d)
		bw(TCT_ADDR_CTRL, 8'h40);
		bw(TCT_ADDR_CTRL, 8'h00);
		br(TCT_ADDR_T1H);
		`CHK("13-bit carry", 8'h13, d)
		br(TCT_ADDR_T1L);
		`CHK("low top", 3'h0, d[7:5])
	endtask
	task automatic t_cap;
		bw(TCT_ADDR_T2L, 8'hFE);
		bw(TCT_ADDR_T2H, 8'hFF);
		bw(TCT_ADDR_IEN, 8'h04);
		bw(TCT_ADDR_T2CTRL, 8'h07);
		pulse(1);
		pulse(1);
		br(TCT_ADDR_T2CTRL);
		`CHK("t2 flag", 1'b1, d[7])
		`CHK("t2 irq", 3'h4, irq)
		pulse(0);
		br(TCT_ADDR_CAPL);
		`CHK("cap off", 8'h00, d)
		bw(TCT_ADDR_T2CTRL, 8'h0F);
		pulse(1);
		pulse(0);
		br(TCT_ADDR_CAPL);
		`CHK("cap low", 8'h01, d)
		br(TCT_ADDR_T2L);
		`CHK("t2 edges", 8'h01, d)
	endtask
	task automatic t_clksel;
		bw(TCT_ADDR_T2CTRL, 8'h00);
		bw(TCT_ADDR_T2L, 8'h00);
		bw(TCT_ADDR_T2H, 8'h00);
		bw(TCT_ADDR_CKSEL, 8'h00);
		bw(TCT_ADDR_T2CTRL, 8'h04);
		repeat (58) @(posedge i_mclk);
		bw(TCT_ADDR_T2CTRL, 8'h00);
		br(TCT_ADDR_T2L);
		`CHK("t2 divided", 8'h05, d)
		bw(TCT_ADDR_T2L, 8'h00);
		bw(TCT_ADDR_T2CTRL, 8'h14);
		repeat (10) @(posedge i_mclk);
		bw(TCT_ADDR_T2CTRL, 8'h00);
		br(TCT_ADDR_T2L);
		`CHK("t2 baud", 8'h0C, d)
		bw(TCT_ADDR_MODE, 8'h10);
		bw(TCT_ADDR_T1L, 8'h00);
		bw(TCT_ADDR_CKSEL, 8'h10);
		bw(TCT_ADDR_CTRL, 8'h40);
		repeat (10) @(posedge i_mclk);
		bw(TCT_ADDR_CTRL, 8'h00);
		br(TCT_ADDR_T1L);
		`CHK("t1 undivided", 8'h0C, d)
	endtask
	task automatic conclude;
		$display("checks %0d errors %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge i_mclk);
		i_nrst <= 1'b1;
		t_regs();
		t_gate();
		t_rate();
		t_reload();
		t_13bit();
		t_cap();
		t_clksel();
		conclude();
	end
	initial begin
		repeat (5000) @(posedge i_mclk);
		$display("FAIL watchdog exp 0 got 1");
		err_count++;
		conclude();
	end
endmodule
`default_nettype wire
